// ==== design/pbr_regs.sv ====
// Operation
// (R1) registers reached by apb at fixed offsets
// (R2) status 11:8 show int lines, zero asserted
// (R3) status fifo size 4:2, fifo count 1:0
// (R4) unmasked masters limited to beat count plus one
// (R5) io access upper address from map 31:16
// (R6) channel count, irq allow need guard bit
// (R7) channel irq flags set, write one clears
// (R8) five dma error flags, write one clears
// (R9) start bit0, halt bit2, active bit3 read-only
// (R10) descriptor pointer written, then tracks current descriptor
// (R11) current channel register shows served channel base
// (R12) each bar has own mapping register
// (R13) per-master pci map, unused low bits zero
// (R14) trace status: first index, waiting, running
// (R15) trace size field shows log2 entries
// (R16) trace go/stop are write-only commands
// (R17) disarm after trigger count; continuous mode only
// (R18) after disarm store delayed-stop entries
// (R19) ad compare with mask zero matching
// (R20) control signals compare with mask
// (R21) sampled ad and control readable
// (R22) trigger needs both compares same cycle
// (R23) reserved bits read zero, ignore writes
`timescale 1ns/1ps
module pbr_regs #(
	parameter logic [2:0] FIFO_SIZE_LOG2 = 3'h3,
	parameter logic [1:0] FIFO_COUNT = 2'h2,
	parameter logic [7:0] TRACE_SIZE_LOG2 = 8'h08,
	parameter logic [31:0] MST_MAP_IMPL = 32'hF0000000
) (
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// status inputs from the bridge core
	input wire logic [3:0] pci_int_n,
	// dma engine side
	input wire logic dma_running,
	input wire logic [7:0] chan_irq_set,
	input wire logic [4:0] dma_err_set,
	input wire logic desc_ptr_load,
	input wire logic [31:0] desc_ptr_value,
	input wire logic [31:0] current_chan_base,
	output logic dma_go_pulse,
	output logic dma_halt_pulse,
	output logic [2:0] dma_chan_count,
	output logic irq_allow,
	output logic [31:0] dma_descriptor_pointer,
	// address mapping
	input wire logic [31:0] bar_map [pbr_pkg::NUM_BARS],
	input wire logic [3:0] bar_sel,
	output logic [31:0] bar_sys_addr,
	input wire logic [3:0] mst_sel,
	output logic [31:0] mst_pci_base,
	output logic mst_burst_limited,
	output logic [8:0] mst_burst_beats,
	output logic [15:0] io_upper_addr,
	// pci trace sampling
	input wire logic [31:0] pci_ad,
	input wire logic [16:0] pci_ctrl,
	input wire logic [15:0] trace_first_index,
	output logic trace_store,
	output logic trace_running
);
	// ************
	// apb decode
	// ************
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic [31:0] rd_word;

	// zero wait states; unmapped addresses answer with an error
	assign wr_en = psel && penable && pwrite; // (R1)
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	// ************
	// pci pin sampling (three stages, change after second and third agree)
	// ************
	// interrupt lines ride on top and reset high, so none reads as asserted
	logic [52:0] smp1_q, smp2_q, smp3_q, pin_q;
	logic [52:0] smp1_d, smp2_d, smp3_d, pin_d;
	logic [52:0] agree;

	// a bit whose last two stages differ keeps its old value
	always_comb begin
		smp1_d = {pci_int_n, pci_ad, pci_ctrl};
		smp2_d = smp1_q;
		smp3_d = smp2_q;
		agree = ~(smp2_q ^ smp3_q);
		pin_d = (smp3_q & agree) | (pin_q & ~agree);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			smp1_q <= {4'hF, 49'h0};
			smp2_q <= {4'hF, 49'h0};
			smp3_q <= {4'hF, 49'h0};
			pin_q <= {4'hF, 49'h0};
		end else begin
			smp1_q <= smp1_d;
			smp2_q <= smp2_d;
			smp3_q <= smp3_d;
			pin_q <= pin_d;
		end
	end

	logic [31:0] ad_now;
	logic [31:0] ctrl_now;
	logic [3:0] int_lines;
	assign ad_now = pin_q[48:17]; // (R21)
	assign ctrl_now = {12'h000, pin_q[16:0], 3'h0} & pbr_pkg::CTRL_FIELD_MASK; // (R21)
	assign int_lines = pin_q[52:49]; // (R2)

	// ************
	// configuration and dma registers
	// ************
	logic [31:0] prefetch_q, prefetch_d;
	logic [31:0] io_map_q, io_map_d;
	logic [2:0] nchan_q, nchan_d;
	logic irq_allow_q, irq_allow_d;
	logic [7:0] chan_irq_flags_q, chan_irq_flags_d;
	logic [4:0] dma_err_q, dma_err_d;
	logic [31:0] desc_q, desc_d;
	logic [31:0] mst_q [pbr_pkg::NUM_MASTERS];
	logic [31:0] mst_d [pbr_pkg::NUM_MASTERS];
	logic dma_wr;

	assign dma_wr = wr_en && hit(paddr, pbr_pkg::OFF_DMA_CS);

	// sticky flags: a hardware set in the clear cycle wins
	always_comb begin
		prefetch_d = prefetch_q;
		io_map_d = io_map_q;
		nchan_d = nchan_q;
		irq_allow_d = irq_allow_q;
		desc_d = desc_q;
		mst_d = mst_q;
		chan_irq_flags_d = chan_irq_flags_q;
		dma_err_d = dma_err_q;
		if (wr_en && hit(paddr, pbr_pkg::OFF_PREFETCH)) begin
			prefetch_d = pwdata & pbr_pkg::PREFETCH_MASK; // (R23)
		end
		if (wr_en && hit(paddr, pbr_pkg::OFF_IO_MAP)) begin
			io_map_d = pwdata & pbr_pkg::IO_MAP_MASK; // (R5)
		end
		if (dma_wr && pwdata[pbr_pkg::DMA_GUARD_BIT]) begin
			nchan_d = pwdata[pbr_pkg::DMA_NCHAN_LSB +: 3]; // (R6)
			irq_allow_d = pwdata[pbr_pkg::DMA_IRQ_ALLOW_BIT]; // (R6)
		end
		if (dma_wr) begin
			chan_irq_flags_d = chan_irq_flags_d & ~pwdata[pbr_pkg::CHAN_IRQ_LSB +: 8]; // (R7)
			dma_err_d = dma_err_d & ~pwdata[pbr_pkg::DMA_ERR_LSB +: 5]; // (R8)
		end
		chan_irq_flags_d = chan_irq_flags_d | chan_irq_set; // (R7)
		dma_err_d = dma_err_d | dma_err_set; // (R8)
		if (wr_en && hit(paddr, pbr_pkg::OFF_DMA_DESC)) begin
			desc_d = pwdata;
		end
		if (desc_ptr_load && dma_running) begin
			desc_d = desc_ptr_value; // (R10)
		end
		// unaligned writes are refused, so they must not land either
		if (wr_en && mapped && paddr >= pbr_pkg::OFF_MST_FIRST
			&& paddr <= pbr_pkg::OFF_MST_LAST) begin
			mst_d[paddr[5:2]] = pwdata & MST_MAP_IMPL; // (R13)
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prefetch_q <= pbr_pkg::RESET_WORD;
			io_map_q <= pbr_pkg::RESET_WORD;
			nchan_q <= 3'h0;
			irq_allow_q <= 1'b0;
			chan_irq_flags_q <= 8'h00;
			dma_err_q <= 5'h00;
			desc_q <= pbr_pkg::RESET_WORD;
			for (int i = 0; i < pbr_pkg::NUM_MASTERS; i++) begin
				mst_q[i] <= pbr_pkg::RESET_WORD;
			end
		end else begin
			prefetch_q <= prefetch_d;
			io_map_q <= io_map_d;
			nchan_q <= nchan_d;
			irq_allow_q <= irq_allow_d;
			chan_irq_flags_q <= chan_irq_flags_d;
			dma_err_q <= dma_err_d;
			desc_q <= desc_d;
			mst_q <= mst_d;
		end
	end

	// start and halt are pulses only; active mirrors the engine
	assign dma_go_pulse = dma_wr && pwdata[pbr_pkg::DMA_GO_BIT]; // (R9)
	assign dma_halt_pulse = dma_wr && pwdata[pbr_pkg::DMA_HALT_BIT]; // (R9)
	assign dma_chan_count = nchan_q;
	assign irq_allow = irq_allow_q;
	assign dma_descriptor_pointer = desc_q;

	// ************
	// mapping lookups for the bridge core
	// ************
	always_comb begin
		bar_sys_addr = 32'h00000000;
		if (bar_sel < 4'(pbr_pkg::NUM_BARS)) begin
			bar_sys_addr = bar_map[3'(bar_sel)]; // (R12)
		end
	end
	assign mst_pci_base = mst_q[mst_sel]; // (R13)
	assign mst_burst_limited = prefetch_q[pbr_pkg::UNMASK_LSB + 32'(mst_sel)]; // (R4)
	assign mst_burst_beats = {1'b0, prefetch_q[7:0]} + 9'h001; // (R4)
	assign io_upper_addr = io_map_q[pbr_pkg::IO_BASE_LSB +: 16]; // (R5)

	// ************
	// trace control
	// ************
	typedef enum logic [1:0] {TRC_IDLE, TRC_ARMED, TRC_DRAIN} pbr_trace_type;
	pbr_trace_type trc_q, trc_d;
	logic [31:0] cnt_mode_q, cnt_mode_d;
	logic [31:0] ad_val_q, ad_val_d, ad_msk_q, ad_msk_d;
	logic [31:0] ct_val_q, ct_val_d, ct_msk_q, ct_msk_d;
	logic [7:0] trig_left_q, trig_left_d;
	logic [15:0] post_left_q, post_left_d;
	logic trig_hit;
	logic go_cmd, stop_cmd;

	assign go_cmd = wr_en && hit(paddr, pbr_pkg::OFF_TRC_CS) && pwdata[pbr_pkg::TRC_GO_BIT]; // (R16)
	assign stop_cmd = wr_en && hit(paddr, pbr_pkg::OFF_TRC_CS) && pwdata[pbr_pkg::TRC_STOP_BIT]; // (R16)
	// both compares on the same sample
	assign trig_hit = (((ad_now ^ ad_val_q) & ad_msk_q) == 32'h00000000) // (R19)
		&& (((ctrl_now ^ ct_val_q) & ct_msk_q) == 32'h00000000); // (R20) (R22)

	// a zero trigger count disarms on the first trigger
	always_comb begin
		trc_d = trc_q;
		trig_left_d = trig_left_q;
		post_left_d = post_left_q;
		cnt_mode_d = cnt_mode_q;
		ad_val_d = ad_val_q;
		ad_msk_d = ad_msk_q;
		ct_val_d = ct_val_q;
		ct_msk_d = ct_msk_q;
		if (wr_en && hit(paddr, pbr_pkg::OFF_TRC_CNT)) begin
			cnt_mode_d = pwdata & pbr_pkg::CNT_MODE_MASK;
		end
		if (wr_en && hit(paddr, pbr_pkg::OFF_TRC_AD_VAL)) begin
			ad_val_d = pwdata;
		end
		if (wr_en && hit(paddr, pbr_pkg::OFF_TRC_AD_MSK)) begin
			ad_msk_d = pwdata;
		end
		if (wr_en && hit(paddr, pbr_pkg::OFF_TRC_CT_VAL)) begin
			ct_val_d = pwdata & pbr_pkg::CTRL_FIELD_MASK; // (R23)
		end
		if (wr_en && hit(paddr, pbr_pkg::OFF_TRC_CT_MSK)) begin
			ct_msk_d = pwdata & pbr_pkg::CTRL_FIELD_MASK; // (R23)
		end
		case (trc_q)
			TRC_IDLE: begin
				// only continuous mode is defined; other codes do not start
				if (go_cmd && cnt_mode_q[pbr_pkg::TRC_MODE_LSB +: 4] == pbr_pkg::MODE_CONTINUOUS) begin
					trc_d = TRC_ARMED;
					trig_left_d = cnt_mode_q[pbr_pkg::TRC_TRIG_LSB +: 8]; // (R17)
				end
			end
			TRC_ARMED: begin
				if (trig_hit) begin
					if (trig_left_q == 8'h00) begin
						trc_d = TRC_DRAIN; // (R17)
						post_left_d = cnt_mode_q[15:0]; // (R18)
					end else begin
						trig_left_d = trig_left_q - 8'h01; // (R17)
					end
				end
			end
			TRC_DRAIN: begin
				if (post_left_q == 16'h0000) begin
					trc_d = TRC_IDLE; // (R18)
				end else begin
					post_left_d = post_left_q - 16'h0001; // (R18)
				end
			end
			default: begin
				trc_d = TRC_IDLE;
			end
		endcase
		if (stop_cmd) begin
			trc_d = TRC_IDLE; // (R16)
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			trc_q <= TRC_IDLE;
			trig_left_q <= 8'h00;
			post_left_q <= 16'h0000;
			cnt_mode_q <= pbr_pkg::RESET_WORD;
			ad_val_q <= pbr_pkg::RESET_WORD;
			ad_msk_q <= pbr_pkg::RESET_WORD;
			ct_val_q <= pbr_pkg::RESET_WORD;
			ct_msk_q <= pbr_pkg::RESET_WORD;
		end else begin
			trc_q <= trc_d;
			trig_left_q <= trig_left_d;
			post_left_q <= post_left_d;
			cnt_mode_q <= cnt_mode_d;
			ad_val_q <= ad_val_d;
			ad_msk_q <= ad_msk_d;
			ct_val_q <= ct_val_d;
			ct_msk_q <= ct_msk_d;
		end
	end

	assign trace_running = (trc_q != TRC_IDLE); // (R14)
	// the last drain cycle does not store, so delayed stop counts entries exactly
	assign trace_store = trace_running && !(trc_q == TRC_DRAIN && post_left_q == 16'h0000);

	// ************
	// read mux, registered read data
	// ************
	always_comb begin
		rd_word = 32'h00000000;
		mapped = 1'b1;
		if (paddr[1:0] != 2'h0) begin
			mapped = 1'b0;
		end else if (paddr >= pbr_pkg::OFF_BAR_FIRST && paddr <= pbr_pkg::OFF_BAR_LAST) begin
			rd_word = bar_map[3'((paddr - pbr_pkg::OFF_BAR_FIRST) >> 2)]; // (R12)
		end else if (paddr >= pbr_pkg::OFF_MST_FIRST && paddr <= pbr_pkg::OFF_MST_LAST) begin
			rd_word = mst_q[paddr[5:2]]; // (R13)
		end else begin
			case (paddr)
				pbr_pkg::OFF_CAP_STATUS: begin
					rd_word[pbr_pkg::HOST_IRQ_LSB +: 4] = int_lines; // (R2)
					rd_word[pbr_pkg::FIFO_SIZE_LSB +: 3] = FIFO_SIZE_LOG2; // (R3)
					rd_word[1:0] = FIFO_COUNT; // (R3)
				end
				pbr_pkg::OFF_PREFETCH: rd_word = prefetch_q;
				pbr_pkg::OFF_IO_MAP: rd_word = io_map_q;
				pbr_pkg::OFF_DMA_CS: begin
					rd_word[pbr_pkg::CHAN_IRQ_LSB +: 8] = chan_irq_flags_q;
					rd_word[pbr_pkg::DMA_ERR_LSB +: 5] = dma_err_q;
					rd_word[pbr_pkg::DMA_NCHAN_LSB +: 3] = nchan_q;
					rd_word[pbr_pkg::DMA_ACTIVE_BIT] = dma_running; // (R9)
					rd_word[pbr_pkg::DMA_IRQ_ALLOW_BIT] = irq_allow_q;
				end
				pbr_pkg::OFF_DMA_DESC: rd_word = desc_q; // (R10)
				pbr_pkg::OFF_DMA_CHAN: rd_word = current_chan_base; // (R11)
				pbr_pkg::OFF_TRC_CS: begin
					rd_word[pbr_pkg::TRC_FIRST_LSB +: 16] = trace_first_index; // (R14)
					rd_word[pbr_pkg::TRC_WAITING_BIT] = (trc_q == TRC_ARMED); // (R14)
					rd_word[pbr_pkg::TRC_RUN_BIT] = trace_running; // (R14)
					rd_word[pbr_pkg::TRC_SIZE_LSB +: 8] = TRACE_SIZE_LOG2; // (R15)
				end
				pbr_pkg::OFF_TRC_CNT: rd_word = cnt_mode_q;
				pbr_pkg::OFF_TRC_AD_VAL: rd_word = ad_val_q;
				pbr_pkg::OFF_TRC_AD_MSK: rd_word = ad_msk_q;
				pbr_pkg::OFF_TRC_CT_VAL: rd_word = ct_val_q;
				pbr_pkg::OFF_TRC_CT_MSK: rd_word = ct_msk_q;
				pbr_pkg::OFF_TRC_AD_SMP: rd_word = ad_now; // (R21)
				pbr_pkg::OFF_TRC_CT_SMP: rd_word = ctrl_now; // (R21)
				default: mapped = 1'b0; // (R23)
			endcase
		end
	end

	logic [31:0] prdata_q, prdata_d;
	// data is captured at setup so it is stable in the access phase
	always_comb begin
		prdata_d = prdata_q;
		if (psel && !penable && !pwrite) begin
			prdata_d = rd_word;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_q <= 32'h00000000;
		end else begin
			prdata_q <= prdata_d;
		end
	end
	assign prdata = rd_en ? prdata_q : 32'h00000000;
endmodule : pbr_regs

// ==== design/pbr_pkg.sv ====
package pbr_pkg;
	// ************
	// register offsets (byte addresses on the apb window)
	// ************
	localparam logic [7:0] OFF_CAP_STATUS = 8'h04;
	localparam logic [7:0] OFF_PREFETCH = 8'h08;
	localparam logic [7:0] OFF_IO_MAP = 8'h0C;
	localparam logic [7:0] OFF_DMA_CS = 8'h10;
	localparam logic [7:0] OFF_DMA_DESC = 8'h14;
	localparam logic [7:0] OFF_DMA_CHAN = 8'h18;
	localparam logic [7:0] OFF_BAR_FIRST = 8'h20;
	localparam logic [7:0] OFF_BAR_LAST = 8'h34;
	localparam logic [7:0] OFF_MST_FIRST = 8'h40;
	localparam logic [7:0] OFF_MST_LAST = 8'h7C;
	localparam logic [7:0] OFF_TRC_CS = 8'h80;
	localparam logic [7:0] OFF_TRC_CNT = 8'h84;
	localparam logic [7:0] OFF_TRC_AD_VAL = 8'h88;
	localparam logic [7:0] OFF_TRC_AD_MSK = 8'h8C;
	localparam logic [7:0] OFF_TRC_CT_VAL = 8'h90;
	localparam logic [7:0] OFF_TRC_CT_MSK = 8'h94;
	localparam logic [7:0] OFF_TRC_AD_SMP = 8'h98;
	localparam logic [7:0] OFF_TRC_CT_SMP = 8'h9C;

	// ************
	// field positions
	// ************
	localparam int HOST_IRQ_LSB = 8;
	localparam int FIFO_SIZE_LSB = 2;
	localparam int UNMASK_LSB = 16;
	localparam int IO_BASE_LSB = 16;
	localparam int DMA_GUARD_BIT = 31;
	localparam int CHAN_IRQ_LSB = 12;
	localparam int DMA_ERR_LSB = 7;
	localparam int DMA_NCHAN_LSB = 4;
	localparam int DMA_ACTIVE_BIT = 3;
	localparam int DMA_HALT_BIT = 2;
	localparam int DMA_IRQ_ALLOW_BIT = 1;
	localparam int DMA_GO_BIT = 0;
	localparam int TRC_FIRST_LSB = 16;
	localparam int TRC_WAITING_BIT = 15;
	localparam int TRC_RUN_BIT = 14;
	localparam int TRC_SIZE_LSB = 4;
	localparam int TRC_STOP_BIT = 1;
	localparam int TRC_GO_BIT = 0;
	localparam int TRC_MODE_LSB = 24;
	localparam int TRC_TRIG_LSB = 16;
	localparam int CTRL_LSB = 3;

	// ************
	// fixed sizes, masks and reset values
	// ************
	localparam int NUM_BARS = 6;
	localparam int NUM_MASTERS = 16;
	localparam logic [31:0] CTRL_FIELD_MASK = 32'h000FFFF8;
	localparam logic [31:0] IO_MAP_MASK = 32'hFFFF0000;
	localparam logic [31:0] PREFETCH_MASK = 32'hFFFF00FF;
	localparam logic [31:0] CNT_MODE_MASK = 32'h0FFFFFFF;
	localparam logic [31:0] RESET_WORD = 32'h00000000;
	localparam logic [3:0] MODE_CONTINUOUS = 4'h0;
endpackage : pbr_pkg

// ==== tb/pbr_regs_checker.sv ====
`timescale 1ns/1ps
// ************
// port checker for the register bank
// ************
module pbr_regs_checker #(
	parameter logic [31:0] MST_MAP_IMPL = 32'hF0000000
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dma_running,
	input wire logic desc_ptr_load,
	input wire logic [31:0] desc_ptr_value,
	input wire logic dma_go_pulse,
	input wire logic dma_halt_pulse,
	input wire logic [2:0] dma_chan_count,
	input wire logic irq_allow,
	input wire logic [31:0] dma_descriptor_pointer,
	input wire logic [31:0] bar_map [pbr_pkg::NUM_BARS],
	input wire logic [3:0] bar_sel,
	input wire logic [31:0] bar_sys_addr,
	input wire logic [31:0] mst_pci_base,
	input wire logic [8:0] mst_burst_beats,
	input wire logic [15:0] io_upper_addr
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// write access phase, shared by most properties
	logic wr_acc;
	assign wr_acc = psel && penable && pwrite;
	property p_unmapped;
		psel && penable && paddr == 8'h00 |-> pslverr && pready && prdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_pulses;
		wr_acc && paddr == pbr_pkg::OFF_DMA_CS |-> dma_go_pulse == pwdata[0] && dma_halt_pulse == pwdata[2];
	endproperty
	a_pulses: assert property (p_pulses) else $error("dma start or stop pulse wrong");
	property p_unguarded;
		wr_acc && paddr == pbr_pkg::OFF_DMA_CS && !pwdata[31] |=> $stable(dma_chan_count) && $stable(irq_allow);
	endproperty
	a_unguarded: assert property (p_unguarded) else $error("guarded field changed");
	property p_guarded;
		wr_acc && paddr == pbr_pkg::OFF_DMA_CS && pwdata[31] |=> dma_chan_count == $past(pwdata[6:4]) && irq_allow == $past(pwdata[1]);
	endproperty
	a_guarded: assert property (p_guarded) else $error("guarded field not written");
	property p_io_map;
		wr_acc && paddr == pbr_pkg::OFF_IO_MAP |=> io_upper_addr == $past(pwdata[31:16]);
	endproperty
	a_io_map: assert property (p_io_map) else $error("io upper address wrong");
	property p_beats;
		wr_acc && paddr == pbr_pkg::OFF_PREFETCH |=> mst_burst_beats == {1'b0, $past(pwdata[7:0])} + 9'h001;
	endproperty
	a_beats: assert property (p_beats) else $error("burst beat limit wrong");
	property p_mst_impl;
		(mst_pci_base & ~MST_MAP_IMPL) == 32'h00000000;
	endproperty
	a_mst_impl: assert property (p_mst_impl) else $error("unimplemented map bits set");
	property p_bar;
		bar_sys_addr == ((bar_sel < 4'h6) ? bar_map[bar_sel] : 32'h00000000);
	endproperty
	a_bar: assert property (p_bar) else $error("bar translation wrong");
	// a hardware load wins over a software write to the pointer; that case is left out here
	property p_desc;
		desc_ptr_load && dma_running && !(wr_acc && paddr == pbr_pkg::OFF_DMA_DESC) |=> dma_descriptor_pointer == $past(desc_ptr_value);
	endproperty
	a_desc: assert property (p_desc) else $error("descriptor pointer not tracked");
endmodule : pbr_regs_checker

bind pbr_regs pbr_regs_checker #(.MST_MAP_IMPL(MST_MAP_IMPL)) chk (
	.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.dma_running(dma_running), .desc_ptr_load(desc_ptr_load), .desc_ptr_value(desc_ptr_value),
	.dma_go_pulse(dma_go_pulse), .dma_halt_pulse(dma_halt_pulse),
	.dma_chan_count(dma_chan_count), .irq_allow(irq_allow),
	.dma_descriptor_pointer(dma_descriptor_pointer), .bar_map(bar_map), .bar_sel(bar_sel),
	.bar_sys_addr(bar_sys_addr), .mst_pci_base(mst_pci_base),
	.mst_burst_beats(mst_burst_beats), .io_upper_addr(io_upper_addr)
);

// ==== tb/pbr_apb_master.sv ====
`timescale 1ns/1ps
// ************
// apb master standing in for processor software
// ************
module pbr_apb_master (
	input wire logic clk,
	input wire logic srst,
	input wire logic go,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output logic done,
	output logic [31:0] rdata,
	output logic err
);
	// setup then access held until pready; released address and data lines are inverted
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (srst) begin
			psel <= 1'b0;
			penable <= 1'b0;
			pwrite <= 1'b0;
			paddr <= 8'h00;
			pwdata <= 32'h00000000;
		end else if (!psel && go) begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= addr;
			pwdata <= wdata;
		end else if (psel && !penable) begin
			penable <= 1'b1;
		end else if (penable && pready) begin
			psel <= 1'b0;
			penable <= 1'b0;
			paddr <= ~paddr;
			pwdata <= ~pwdata;
			rdata <= prdata;
			err <= pslverr;
			done <= 1'b1;
		end
	end
endmodule : pbr_apb_master

// ==== tb/test_pci_bridge_dma_trace_registers.sv ====
`timescale 1ns/1ps
module test_pci_bridge_dma_trace_registers;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, dma_running, desc_ptr_load;
	logic go, wr, done, err, dma_go_pulse, dma_halt_pulse, irq_allow, trace_store;
	logic mst_burst_limited, trace_running;
	logic [7:0] paddr, addr, chan_irq_set;
	logic [31:0] pwdata, prdata, wdata, rdata, desc_ptr_value, current_chan_base, pci_ad, rd;
	logic [31:0] dma_descriptor_pointer, bar_sys_addr, mst_pci_base;
	logic [31:0] bar_map [pbr_pkg::NUM_BARS];
	logic [3:0] pci_int_n, bar_sel, mst_sel;
	logic [4:0] dma_err_set;
	logic [2:0] dma_chan_count;
	logic [8:0] mst_burst_beats;
	logic [15:0] io_upper_addr, trace_first_index;
	logic [16:0] pci_ctrl;
	logic [7:0] zero_offs [12] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h40, 8'h7C, 8'h84, 8'h88,
		8'h8C, 8'h90, 8'h94, 8'h98};
	logic [7:0] bad_offs [5] = '{8'h00, 8'h1C, 8'h38, 8'h3C, 8'h06};
	int err_total, num_checks, gap;
	// ************
	// clock, design and bus master
	// ************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	pbr_regs uut (
		.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pci_int_n(pci_int_n), .dma_running(dma_running), .chan_irq_set(chan_irq_set),
		.dma_err_set(dma_err_set), .desc_ptr_load(desc_ptr_load),
		.desc_ptr_value(desc_ptr_value), .current_chan_base(current_chan_base),
		.dma_go_pulse(dma_go_pulse), .dma_halt_pulse(dma_halt_pulse),
		.dma_chan_count(dma_chan_count), .irq_allow(irq_allow),
		.dma_descriptor_pointer(dma_descriptor_pointer), .bar_map(bar_map), .bar_sel(bar_sel),
		.bar_sys_addr(bar_sys_addr), .mst_sel(mst_sel), .mst_pci_base(mst_pci_base),
		.mst_burst_limited(mst_burst_limited), .mst_burst_beats(mst_burst_beats),
		.io_upper_addr(io_upper_addr), .pci_ad(pci_ad), .pci_ctrl(pci_ctrl),
		.trace_first_index(trace_first_index), .trace_store(trace_store),
		.trace_running(trace_running)
	);
	pbr_apb_master host (
		.clk(clk), .srst(srst), .go(go), .wr(wr), .addr(addr), .wdata(wdata), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .done(done), .rdata(rdata), .err(err)
	);
	// ************
	// tasks
	// ************
	task automatic results;
		$display("comparisons %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk32
	task automatic chk1(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %b seen %b", what, exp, got);
		end
	endtask : chk1
	// one whole transfer; a hung bus ends the run
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		go <= 1'b1;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		go <= 1'b0;
		for (n = 0; n < 10 && done !== 1'b1; n++) @(posedge clk);
		if (done !== 1'b1) begin
			err_total++;
			results();
		end
		rd = rdata;
	endtask : xfer
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e);
		xfer(1'b0, a, 32'h00000000);
		chk32($sformatf("read %h", a), exp, rd);
		chk1($sformatf("error %h", a), e, err);
	endtask : rdchk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// ************
	// sequence
	// ************
	initial begin
		err_total = 0;
		num_checks = 0;
		srst = 1'b1;
		go = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h00000000;
		pci_int_n = 4'hF;
		dma_running = 1'b0;
		chan_irq_set = 8'h00;
		dma_err_set = 5'h00;
		desc_ptr_load = 1'b0;
		desc_ptr_value = 32'h00000000;
		current_chan_base = 32'hCAFE0010;
		bar_sel = 4'h0;
		mst_sel = 4'h0;
		pci_ad = 32'h00000000;
		pci_ctrl = 17'h00000;
		trace_first_index = 16'h1234;
		foreach (bar_map[i]) bar_map[i] = 32'h40000000 + 32'(i) * 32'h00000100;
		tick(3);
		srst <= 1'b0;
		// reset values, refused places, read-only words
		rdchk(pbr_pkg::OFF_CAP_STATUS, 32'h00000F0E, 1'b0);
		foreach (zero_offs[i]) rdchk(zero_offs[i], pbr_pkg::RESET_WORD, 1'b0);
		foreach (bad_offs[i]) rdchk(bad_offs[i], 32'h00000000, 1'b1);
		rdchk(pbr_pkg::OFF_TRC_CS, 32'h12340080, 1'b0);
		rdchk(pbr_pkg::OFF_DMA_CHAN, 32'hCAFE0010, 1'b0);
		xfer(1'b1, pbr_pkg::OFF_BAR_FIRST, 32'hFFFFFFFF);
		for (int i = 0; i < 8; i++) begin
			if (i < 6) rdchk(pbr_pkg::OFF_BAR_FIRST + 8'(4 * i), bar_map[i], 1'b0);
			bar_sel <= 4'(i);
			tick(1);
			chk32("bar address", i < 6 ? bar_map[i] : 32'h00000000, bar_sys_addr);
		end
		// master maps: only the implemented top bits hold
		for (int i = 0; i < 16; i++) begin
			xfer(1'b1, pbr_pkg::OFF_MST_FIRST + 8'(4 * i), {4'(i), 28'hFFFFFFF});
			rdchk(pbr_pkg::OFF_MST_FIRST + 8'(4 * i), {4'(i), 28'h0000000}, 1'b0);
			mst_sel <= 4'(i);
			tick(1);
			chk32("master base", {4'(i), 28'h0000000}, mst_pci_base);
		end
		xfer(1'b1, pbr_pkg::OFF_PREFETCH, 32'hFFFFFFFF);
		rdchk(pbr_pkg::OFF_PREFETCH, 32'hFFFF00FF, 1'b0);
		chk32("beats", 32'h00000100, {23'h000000, mst_burst_beats});
		xfer(1'b1, pbr_pkg::OFF_PREFETCH, 32'h00050003);
		chk1("limited", 1'b0, mst_burst_limited);
		mst_sel <= 4'h2;
		tick(1);
		chk1("limited", 1'b1, mst_burst_limited);
		xfer(1'b1, pbr_pkg::OFF_IO_MAP, 32'hFFFFFFFF);
		rdchk(pbr_pkg::OFF_IO_MAP, 32'hFFFF0000, 1'b0);
		chk32("io upper", 32'h0000FFFF, {16'h0000, io_upper_addr});
		// guard, commands, sticky flags
		xfer(1'b1, pbr_pkg::OFF_DMA_CS, 32'h00000072);
		rdchk(pbr_pkg::OFF_DMA_CS, 32'h00000000, 1'b0);
		xfer(1'b1, pbr_pkg::OFF_DMA_CS, 32'h80000072);
		dma_running <= 1'b1;
		rdchk(pbr_pkg::OFF_DMA_CS, 32'h0000007A, 1'b0);
		xfer(1'b1, pbr_pkg::OFF_DMA_CS, 32'h0000000D);
		chan_irq_set <= 8'h81;
		dma_err_set <= 5'h11;
		tick(1);
		chan_irq_set <= 8'h00;
		dma_err_set <= 5'h00;
		rdchk(pbr_pkg::OFF_DMA_CS, 32'h000818FA, 1'b0);
		xfer(1'b1, pbr_pkg::OFF_DMA_CS, 32'h00001080);
		rdchk(pbr_pkg::OFF_DMA_CS, 32'h0008087A, 1'b0);
		xfer(1'b1, pbr_pkg::OFF_DMA_DESC, 32'h00001000);
		desc_ptr_value <= 32'h00002000;
		desc_ptr_load <= 1'b1;
		tick(1);
		desc_ptr_load <= 1'b0;
		rdchk(pbr_pkg::OFF_DMA_DESC, 32'h00002000, 1'b0);
		chk32("desc out", 32'h00002000, dma_descriptor_pointer);
		pci_int_n <= 4'hA;
		tick(5);
		rdchk(pbr_pkg::OFF_CAP_STATUS, 32'h00000A0E, 1'b0);
		// trace: ad matches, control does not, so it must stay armed
		xfer(1'b1, pbr_pkg::OFF_TRC_AD_VAL, 32'hABCD0000);
		xfer(1'b1, pbr_pkg::OFF_TRC_AD_MSK, 32'hFFFF0000);
		xfer(1'b1, pbr_pkg::OFF_TRC_CT_VAL, 32'hFFFFFFFF);
		rdchk(pbr_pkg::OFF_TRC_CT_VAL, 32'h000FFFF8, 1'b0);
		xfer(1'b1, pbr_pkg::OFF_TRC_CT_MSK, 32'h00000008);
		xfer(1'b1, pbr_pkg::OFF_TRC_CNT, 32'hF0010003);
		rdchk(pbr_pkg::OFF_TRC_CNT, 32'h00010003, 1'b0);
		pci_ad <= 32'hABCD5555;
		xfer(1'b1, pbr_pkg::OFF_TRC_CS, 32'h00000001);
		tick(8);
		xfer(1'b0, pbr_pkg::OFF_TRC_CS, 32'h00000000);
		chk32("armed", 32'h00008000, rd & 32'h00008003);
		rdchk(pbr_pkg::OFF_TRC_AD_SMP, 32'hABCD5555, 1'b0);
		pci_ctrl <= 17'h00001;
		gap = 0;
		// only the final drain cycle runs without storing
		for (int n = 0; n < 40 && trace_running !== 1'b0; n++) begin
			tick(1);
			gap += (trace_running && !trace_store);
		end
		chk1("running", 1'b0, trace_running);
		chk32("unstored drain cycles", 32'h00000001, gap);
		rdchk(pbr_pkg::OFF_TRC_CT_SMP, 32'h00000008, 1'b0);
		rdchk(pbr_pkg::OFF_TRC_CS, 32'h12340080, 1'b0);
		// control matches now, upper ad does not: must stay armed
		pci_ad <= 32'h12345555;
		tick(4);
		xfer(1'b1, pbr_pkg::OFF_TRC_CS, 32'h00000001);
		tick(8);
		chk1("running", 1'b1, trace_running);
		xfer(1'b1, pbr_pkg::OFF_TRC_CS, 32'h00000002);
		chk1("running", 1'b0, trace_running);
		xfer(1'b1, pbr_pkg::OFF_TRC_CNT, 32'h01010003);
		xfer(1'b1, pbr_pkg::OFF_TRC_CS, 32'h00000001);
		rdchk(pbr_pkg::OFF_TRC_CS, 32'h12340080, 1'b0);
		results();
	end
endmodule : test_pci_bridge_dma_trace_registers
